// ===== logic/sdc_top.sv
// sigma-delta converter control, comb decimator and register slave
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sdc_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // modulator side
    input wire logic mod_bit,
    output logic modulator_sample_clock,
    output logic modulator_reset,
    output logic converter_power_up,
    // analog controls
    output logic [5:0] gain_sel,
    output logic signed [2:0] dc_offset_quarters,
    output logic reference_halve,
    output logic chopper_bypass,
    output logic test_gain_bit,
    output logic input_short,
    output logic [7:0] pos_input_sel,
    output logic [7:0] neg_input_sel,
    output logic [3:0] pos_ref_sel,
    output logic [3:0] neg_ref_sel,
    output logic [3:0] swap_route,
    // event flag and its enable, gated with the global enable outside
    output logic conversion_done_flag,
    output logic conversion_irq_enable
);
    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] ctl3;
        logic [7:0] net1;
        logic [7:0] net2;
        logic [7:0] misc;
        logic [23:0] result;
        logic done;
        logic tick;
        logic [sdc_pkg::DIV_W-1:0] div_cnt;
        logic [sdc_pkg::DEC_W-1:0] dec_cnt;
        logic [sdc_pkg::ACC_W-1:0] int1;
        logic [sdc_pkg::ACC_W-1:0] int2;
        logic [sdc_pkg::ACC_W-1:0] comb1;
        logic [sdc_pkg::ACC_W-1:0] comb2;
    } sdc_state_s;

    sdc_state_s q;
    sdc_state_s d;

    // scale sinc2 output of gain R*R down or up to full scale 2**22
    function automatic logic [23:0] sdc_scale(input logic [31:0] v, input logic [3:0] code);
        logic signed [31:0] s;
        int sh;
        s = v;
        sh = 2 * (int'(code) + sdc_pkg::OSR_BASE_LOG2) - sdc_pkg::FS_LOG2;
        if (sh >= 0) begin
            s = s >>> sh;
        end else begin
            s = s <<< (-sh);
        end
        return s[23:0];
    endfunction : sdc_scale

    // local copies of the counter widths, declared before the casts that use them
    localparam int DIV_W = sdc_pkg::DIV_W;
    localparam int DEC_W = sdc_pkg::DEC_W;

    logic [3:0] osr_code;
    logic [2:0] pre_code;
    logic [sdc_pkg::DIV_W-1:0] div_last;
    logic [sdc_pkg::DEC_W-1:0] dec_last;
    logic filt_hold;
    logic wr_go;
    logic done_clr;
    logic [sdc_pkg::ACC_W-1:0] x;
    logic [sdc_pkg::ACC_W-1:0] i1n;
    logic [sdc_pkg::ACC_W-1:0] i2n;
    logic [sdc_pkg::ACC_W-1:0] d1;

    // ratio code above the last documented one is clamped
    assign osr_code = (q.ctl3[7:4] > sdc_pkg::OSR_MAX_CODE) ? sdc_pkg::OSR_MAX_CODE : q.ctl3[7:4];
    assign pre_code = q.misc[sdc_pkg::MISC_PRE_LSB+2:sdc_pkg::MISC_PRE_LSB];
    assign div_last = DIV_W'((1 << (int'(pre_code) + sdc_pkg::PRE_BASE_LOG2)) - 1);
    assign dec_last = DEC_W'((1 << (int'(osr_code) + sdc_pkg::OSR_BASE_LOG2)) - 1);
    // reset bit or a cleared enable holds the filter
    assign filt_hold = q.misc[sdc_pkg::MISC_RST] | ~q.ctl1[sdc_pkg::CTL1_EN];
    assign wr_go = q.aw_have & q.w_have & ~q.bvalid;
    assign done_clr = wr_go & q.w_lane0 & (q.aw_addr == sdc_pkg::OFF_STAT)
        & q.w_data[sdc_pkg::STAT_DONE];

    // bus handshakes come straight from state
    assign s_axi_awready = ~q.aw_have;
    assign s_axi_wready = ~q.w_have;
    assign s_axi_arready = ~q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = {24'h000000, q.rdata};

    // next state: bus slave, registers, divider and decimator
    always_comb begin
        d = q;
        x = mod_bit ? 32'h00000001 : 32'hFFFFFFFF;
        i1n = q.int1 + x;
        i2n = q.int2 + i1n;
        d1 = i2n - q.comb1;
        // write channels are taken in either order
        if (s_axi_awvalid && !q.aw_have) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_have) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata[7:0];
            d.w_lane0 = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_go) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = sdc_pkg::RESP_OKAY;
            case (q.aw_addr)
                sdc_pkg::OFF_CTL1: if (q.w_lane0) d.ctl1 = q.w_data & 8'hE7;
                sdc_pkg::OFF_CTL2: if (q.w_lane0) d.ctl2 = q.w_data & 8'h0F;
                sdc_pkg::OFF_CTL3: if (q.w_lane0) d.ctl3 = q.w_data & 8'hF0;
                sdc_pkg::OFF_NET1: if (q.w_lane0) d.net1 = q.w_data & 8'hFE;
                sdc_pkg::OFF_NET2: if (q.w_lane0) d.net2 = q.w_data & 8'h7E;
                sdc_pkg::OFF_MISC: if (q.w_lane0) d.misc = q.w_data & 8'h1F;
                // result bytes ignore writes; status is write-one-to-clear
                sdc_pkg::OFF_STAT, sdc_pkg::OFF_RES_HI,
                sdc_pkg::OFF_RES_MID, sdc_pkg::OFF_RES_LO: d.bresp = sdc_pkg::RESP_OKAY;
                default: d.bresp = sdc_pkg::RESP_SLVERR;
            endcase
        end
        // read side: one outstanding read, answered the cycle after
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = sdc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                sdc_pkg::OFF_RES_HI: d.rdata = q.result[23:16];
                sdc_pkg::OFF_RES_MID: d.rdata = q.result[15:8];
                sdc_pkg::OFF_RES_LO: d.rdata = q.result[7:0];
                sdc_pkg::OFF_CTL1: d.rdata = q.ctl1;
                sdc_pkg::OFF_CTL2: d.rdata = q.ctl2;
                sdc_pkg::OFF_CTL3: d.rdata = q.ctl3;
                sdc_pkg::OFF_NET1: d.rdata = q.net1;
                sdc_pkg::OFF_NET2: d.rdata = q.net2;
                sdc_pkg::OFF_STAT: d.rdata = {6'h00, ~filt_hold, q.done};
                sdc_pkg::OFF_MISC: d.rdata = q.misc;
                default: begin
                    d.rdata = 8'h00;
                    d.rresp = sdc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // clear first so that a same-cycle completion wins
        if (done_clr) begin
            d.done = 1'b0;
        end
        d.tick = 1'b0;
        if (filt_hold) begin
            // modulator and filter held while reset or off
            d.div_cnt = '0;
            d.dec_cnt = '0;
            d.int1 = '0;
            d.int2 = '0;
            d.comb1 = '0;
            d.comb2 = '0;
        end else begin
            // sample enable pulse from the prescaler
            if (q.div_cnt >= div_last) begin
                d.div_cnt = '0;
                d.tick = 1'b1;
            end else begin
                d.div_cnt = q.div_cnt + 1'b1;
            end
            if (q.tick) begin
                // two integrators run at the sample rate
                d.int1 = i1n;
                d.int2 = i2n;
                if (q.dec_cnt >= dec_last) begin
                    // one comb step per decimation period
                    d.dec_cnt = '0;
                    d.comb1 = i2n;
                    d.comb2 = d1;
                    // whole 24-bit word stored in one cycle
                    d.result = sdc_scale(d1 - q.comb2, osr_code);
                    // flag set on every stored result
                    d.done = 1'b1;
                end else begin
                    d.dec_cnt = q.dec_cnt + 1'b1;
                end
            end
        end
    end

    // single state register, synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // power follows the enable bit; run also needs the reset bit clear
    assign converter_power_up = q.ctl1[sdc_pkg::CTL1_EN];
    assign modulator_reset = filt_hold;
    assign modulator_sample_clock = q.tick;
    assign conversion_done_flag = q.done;
    assign conversion_irq_enable = q.misc[sdc_pkg::MISC_IE];
    assign test_gain_bit = q.ctl1[sdc_pkg::CTL1_TEST];
    assign chopper_bypass = q.ctl1[sdc_pkg::CTL1_CHOP];
    assign reference_halve = q.ctl2[sdc_pkg::CTL2_VRG];
    assign input_short = q.net1[sdc_pkg::NET1_SHORT];
    // signed quarters; codes 000 and 100 both give zero
    assign dc_offset_quarters = q.ctl2[2] ? -$signed({1'b0, q.ctl2[1:0]})
        : $signed({1'b0, q.ctl2[1:0]});

    // analog selector decodes; all but swap_route set at most one bit so the pads never see two paths, swap_route sets two
    always_comb begin
        // gain one-hot: bit0 half .. bit5 sixteen, 000 and 111 none
        gain_sel = 6'h00;
        if (q.ctl1[2:0] != 3'h0 && q.ctl1[2:0] != 3'h7) begin
            gain_sel[q.ctl1[2:0] - 3'h1] = 1'b1;
        end
        // bits 0..3 inputs 0,2,4,6; 4 half, 5 quarter, 6 supply, 7 ground
        pos_input_sel = 8'h00;
        pos_input_sel[q.net1[7:5]] = 1'b1;
        // bits 0..3 inputs 1,3,5,7; 6 common mode; 7 ground
        neg_input_sel = 8'h00;
        if (q.net1[4:3] != 2'h2) begin
            neg_input_sel[q.net1[4:2]] = 1'b1;
        end
        // positive: supply, common mode, in0, in1
        pos_ref_sel = 4'h0;
        pos_ref_sel[q.net2[6:5]] = 1'b1;
        neg_ref_sel = 4'h0;
        neg_ref_sel[q.net2[2:1]] = 1'b1;
        case (q.net2[4:3])
            2'h0: swap_route = 4'h9;
            2'h1: swap_route = 4'h5;
            2'h2: swap_route = 4'hA;
            2'h3: swap_route = 4'h6;
            default: swap_route = 4'h9;
        endcase
    end

    // helper: cycles since the last sample tick, saturating at 15
    logic [3:0] since_upd;
    always_ff @(posedge aclk) begin
        if (!aresetn || q.tick) begin
            since_upd <= 4'h0;
        end else if (since_upd != 4'hF) begin
            since_upd <= since_upd + 4'h1;
        end
    end

    a_done_on_result: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $changed(q.result) |-> q.done)
        else $error("result stored without done flag");
    a_result_on_tick: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $changed(q.result) |-> $past(q.tick) && $past(q.dec_cnt) == $past(dec_last))
        else $error("result changed outside a decimation boundary");
    a_hold_clears: assert property (
        @(posedge aclk) disable iff (!aresetn)
        filt_hold |=> q.int1 == '0 && q.dec_cnt == '0 && !q.tick)
        else $error("filter not held in reset");
    a_set_beats_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        done_clr && d.result != q.result |=> q.done)
        else $error("completion lost against clear");
    a_power_follows: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !converter_power_up |-> modulator_reset ##1 $stable(q.result))
        else $error("converter ran while disabled");
    a_gain_onehot: assert property (
        @(posedge aclk) disable iff (!aresetn)
        q.ctl1[2:0] == 3'h2 |-> gain_sel == 6'h02)
        else $error("unity gain misdecoded");
    a_swap_route: assert property (
        @(posedge aclk) disable iff (!aresetn)
        q.net2[4:3] == 2'h3 |-> swap_route == 4'h6)
        else $error("swap misdecoded");
    a_neg_unused: assert property (
        @(posedge aclk) disable iff (!aresetn)
        q.net1[4:3] == 2'h2 |-> neg_input_sel == 8'h00)
        else $error("unused negative code selected a path");
    a_tick_spacing: assert property (
        @(posedge aclk) disable iff (!aresetn)
        q.tick && !filt_hold && $stable(pre_code) |=> !q.tick [*7])
        else $error("sample enable faster than prescaler allows");
    a_offset_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        q.ctl2[1:0] == 2'h0 |-> dc_offset_quarters == 3'sd0)
        else $error("zero offset misdecoded");
    a_bresp_soon: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_axi_bvalid)
        else $error("write not answered");
    a_since_used: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $changed(q.result) |-> since_upd == 4'h0)
        else $error("result moved away from a sample edge");
endmodule : sdc_top

// ===== logic/sdc_pkg.sv
// constants shared by the sigma-delta converter control block
package sdc_pkg;
    // clock rate of aclk in hertz
    localparam int unsigned CLK_HZ = 10_000_000;
    // register byte offsets
    localparam logic [7:0] OFF_RES_HI = 8'h00;
    localparam logic [7:0] OFF_RES_MID = 8'h04;
    localparam logic [7:0] OFF_RES_LO = 8'h08;
    localparam logic [7:0] OFF_CTL1 = 8'h0C;
    localparam logic [7:0] OFF_CTL2 = 8'h10;
    localparam logic [7:0] OFF_CTL3 = 8'h14;
    localparam logic [7:0] OFF_NET1 = 8'h18;
    localparam logic [7:0] OFF_NET2 = 8'h1C;
    localparam logic [7:0] OFF_STAT = 8'h20;
    localparam logic [7:0] OFF_MISC = 8'h24;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // field positions
    localparam int CTL1_EN = 7;
    localparam int CTL1_TEST = 6;
    localparam int CTL1_CHOP = 5;
    localparam int CTL2_VRG = 3;
    localparam int NET1_SHORT = 1;
    localparam int STAT_DONE = 0;
    localparam int STAT_RUN = 1;
    localparam int MISC_RST = 0;
    localparam int MISC_IE = 1;
    localparam int MISC_PRE_LSB = 2;
    // decimation ratio is 2**(code + OSR_BASE_LOG2)
    localparam int OSR_BASE_LOG2 = 5;
    localparam logic [3:0] OSR_MAX_CODE = 4'hA;
    // sample clock divisor is 2**(code + PRE_BASE_LOG2)
    localparam int PRE_BASE_LOG2 = 3;
    // full scale result is 2**FS_LOG2
    localparam int FS_LOG2 = 22;
    localparam int ACC_W = 32;
    localparam int DIV_W = 11;
    localparam int DEC_W = 15;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sdc_pkg

// ===== verif/sdc_mod_model.sv
// behavioural modulator feeding the one-bit stream into the block
`timescale 1ns/1ps
module sdc_mod_model (
    // clock
    input wire logic aclk,
    // controls from the block and the bench
    input wire logic sample_tick,
    input wire logic hold_reset,
    input wire logic level,
    // bit stream
    output logic mod_bit
);
    // new bit after each tick; in reset the line wanders so stale data never looks valid
    always @(posedge aclk) begin
        if (hold_reset) begin
            mod_bit <= ~mod_bit;
        end else if (sample_tick) begin
            mod_bit <= level;
        end
    end
    initial mod_bit = 1'b0;
endmodule : sdc_mod_model

// ===== verif/tb_top.sv
// self-checking bench for the sigma-delta converter control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    if ((got) !== (exp)) begin \
        $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
        num_errors++; \
    end \
    comparisons++;
module tb_top;
    logic aclk = 0, aresetn = 0, stream_level = 0, mod_bit;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0, pos_ref_sel, neg_ref_sel, swap_route;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, modulator_sample_clock, modulator_reset, converter_power_up;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] gain_sel;
    logic signed [2:0] dc_offset_quarters;
    logic reference_halve, chopper_bypass, test_gain_bit, input_short;
    logic [7:0] pos_input_sel, neg_input_sel;
    logic conversion_done_flag, conversion_irq_enable;
    int num_errors = 0, comparisons = 0, cyc = 0;
    // 10 MHz clock and a free cycle count for period checks
    always #50 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    sdc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .mod_bit(mod_bit),
        .modulator_sample_clock(modulator_sample_clock), .modulator_reset(modulator_reset),
        .converter_power_up(converter_power_up), .gain_sel(gain_sel),
        .dc_offset_quarters(dc_offset_quarters), .reference_halve(reference_halve),
        .chopper_bypass(chopper_bypass), .test_gain_bit(test_gain_bit),
        .input_short(input_short), .pos_input_sel(pos_input_sel),
        .neg_input_sel(neg_input_sel), .pos_ref_sel(pos_ref_sel), .neg_ref_sel(neg_ref_sel),
        .swap_route(swap_route), .conversion_done_flag(conversion_done_flag),
        .conversion_irq_enable(conversion_irq_enable));
    sdc_mod_model partner (.aclk(aclk), .sample_tick(modulator_sample_clock),
        .hold_reset(modulator_reset), .level(stream_level), .mod_bit(mod_bit));
    // verdict and end of run
    task automatic close_out();
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // bus write; both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        `CHK("bresp", sdc_pkg::RESP_OKAY, s_axi_bresp)
        s_axi_bready <= 1'b0;
        // one idle edge so a following call never reassigns bready in this step
        @(posedge aclk);
    endtask : wr
    // bus read; waits for the answer, no latency assumed
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        // one idle edge so a following call never reassigns rready in this step
        @(posedge aclk);
    endtask : rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK(nm, e, d)
        `CHK("rresp", sdc_pkg::RESP_OKAY, r)
    endtask : rd_chk
    // register reset values, unmapped place, read-only and strobe-less writes
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        for (int a = 0; a <= 36; a += 4) rd_chk(a[7:0], 32'h0, "reset_reg");
        rd(8'h28, d, r);
        `CHK("unmapped_resp", sdc_pkg::RESP_SLVERR, r)
        `CHK("unmapped_data", 32'h0, d)
        `CHK("mod_reset", 1'b1, modulator_reset)
        wr(sdc_pkg::OFF_CTL2, 32'hFF, 4'h0);
        rd_chk(sdc_pkg::OFF_CTL2, 32'h0, "ctl2_nostrb");
        wr(sdc_pkg::OFF_RES_HI, 32'h55, 4'hF);
        rd_chk(sdc_pkg::OFF_RES_HI, 32'h0, "res_hi_ro");
    endtask : t_regs
    // every code of every analog control field, decoded at the ports
    task automatic t_decode();
        logic [2:0] c;
        logic signed [2:0] dq [8] = '{3'sh0, 3'sh1, 3'sh2, 3'sh3, 3'sh0, 3'sh7, 3'sh6, 3'sh5};
        logic [3:0] sw [4] = '{4'h9, 4'h5, 4'hA, 4'h6};
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(sdc_pkg::OFF_CTL1, {24'h0, 1'b0, c[2], c[1], 2'b0, c}, 4'hF);
            wr(sdc_pkg::OFF_CTL2, {24'h0, 4'h0, c[0], c}, 4'hF);
            wr(sdc_pkg::OFF_NET1, {24'h0, c, c, c[0], 1'b0}, 4'hF);
            wr(sdc_pkg::OFF_NET2, {24'h0, 1'b0, c[1:0], c[1:0], c[1:0], 1'b0}, 4'hF);
            `CHK("gain", (c == 0 || c == 7) ? 6'h00 : 6'h01 << (c - 1), gain_sel)
            `CHK("dc_offset", dq[c], dc_offset_quarters)
            `CHK("ref_halve", c[0], reference_halve)
            `CHK("chop_bypass", c[1], chopper_bypass)
            `CHK("test_gain", c[2], test_gain_bit)
            `CHK("short", c[0], input_short)
            `CHK("pos_in", 8'h01 << c, pos_input_sel)
            `CHK("neg_in", (c == 4 || c == 5) ? 8'h00 : 8'h01 << c, neg_input_sel)
            `CHK("pos_ref", 4'h1 << c[1:0], pos_ref_sel)
            `CHK("neg_ref", 4'h1 << c[1:0], neg_ref_sel)
            `CHK("swap", sw[c[1:0]], swap_route)
            `CHK("power_up", 1'b0, converter_power_up)
            rd_chk(sdc_pkg::OFF_CTL1, {24'h0, 1'b0, c[2], c[1], 2'b0, c}, "ctl1_rw");
        end
    endtask : t_decode
    // cycles from one sample tick to the next
    task automatic tick_gap(input int e);
        int k;
        k = 1;
        while (modulator_sample_clock !== 1'b1) @(posedge aclk);
        @(posedge aclk);
        while (modulator_sample_clock !== 1'b1) begin
            @(posedge aclk);
            k++;
        end
        `CHK("tick_gap", e, k)
    endtask : tick_gap
    task automatic wait_flag(output int t);
        wr(sdc_pkg::OFF_STAT, 32'h1, 4'hF);
        while (conversion_done_flag !== 1'b1) @(posedge aclk);
        t = cyc;
    endtask : wait_flag
    // full-scale stream; transients skipped, then period and result bytes judged
    task automatic t_conv(input logic [2:0] pre, input logic [3:0] osr, input logic lvl,
            input logic [7:0] hi);
        int t0;
        int t1;
        stream_level <= lvl;
        // irq enable set by software; tick kept in range
        wr(sdc_pkg::OFF_MISC, {27'h0, pre, 2'b10}, 4'hF);
        wr(sdc_pkg::OFF_CTL3, {24'h0, osr, 4'h0}, 4'hF);
        // regulator and common mode taken as up before enable
        wr(sdc_pkg::OFF_CTL1, 32'h82, 4'hF);
        `CHK("power_up", 1'b1, converter_power_up)
        `CHK("mod_reset", 1'b0, modulator_reset)
        `CHK("irq_en", 1'b1, conversion_irq_enable)
        tick_gap(8 << pre);
        for (int k = 0; k < 4; k++) begin
            t0 = t1;
            wait_flag(t1);
        end
        `CHK("period", (32 << osr) * (8 << pre), t1 - t0)
        rd_chk(sdc_pkg::OFF_RES_HI, {24'h0, hi}, "res_hi");
        rd_chk(sdc_pkg::OFF_RES_MID, 32'h0, "res_mid");
        rd_chk(sdc_pkg::OFF_RES_LO, 32'h0, "res_lo");
        wr(sdc_pkg::OFF_CTL1, 32'h0, 4'hF);
        `CHK("power_down", 1'b0, converter_power_up)
        `CHK("mod_reset_off", 1'b1, modulator_reset)
    endtask : t_conv
    // reset bit holds the filter: no result for well over one period
    task automatic t_hold();
        wr(sdc_pkg::OFF_MISC, 32'h0D, 4'hF);
        wr(sdc_pkg::OFF_CTL1, 32'h82, 4'hF);
        `CHK("held", 1'b1, modulator_reset)
        wr(sdc_pkg::OFF_STAT, 32'h1, 4'hF);
        repeat (5000) @(posedge aclk);
        `CHK("held_flag", 1'b0, conversion_done_flag)
        wr(sdc_pkg::OFF_CTL1, 32'h0, 4'hF);
    endtask : t_hold
    // supply off: selectors steered to ground and common mode
    task automatic t_park();
        wr(sdc_pkg::OFF_NET1, 32'hFC, 4'hF);
        wr(sdc_pkg::OFF_NET2, 32'h20, 4'hF);
        `CHK("park_pos", 8'h80, pos_input_sel)
        `CHK("park_neg", 8'h80, neg_input_sel)
        `CHK("park_pref", 4'h2, pos_ref_sel)
        `CHK("park_nref", 4'h1, neg_ref_sel)
    endtask : t_park
    // main sequence; prescaler 3 and 4 keep the tick at 156 and 78 kHz
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_decode();
        t_conv(3'h3, 4'h0, 1'b1, 8'h40);
        t_conv(3'h3, 4'h1, 1'b0, 8'hC0);
        t_conv(3'h4, 4'h0, 1'b1, 8'h40);
        t_hold();
        t_park();
        close_out();
    end
    // hang guard, about twice the expected 46k cycles
    initial begin
        repeat (90000) @(posedge aclk);
        num_errors++;
        close_out();
    end
endmodule : tb_top
